/* test/ber_bus_model.sv */
// Bus-side model: turns a numbered event request from the bench into the
// one-cycle pulses and levels that the bridge's bus logic would present.
// Assumes the bench changes kind and fire just after a rising clock edge.

`timescale 1ns/100ps

module ber_bus_model
(
    // Request from the bench
    input wire logic [4:0] kind,
    input wire logic fire,
    // Event lines towards the block
    output logic [19:0] ev,
    output logic sec_serr_n
);
    // ------------------------------------------------------------
    // Event decode
    // ------------------------------------------------------------
    // One event per cycle keeps each cause distinct; lock lines of both sides are separate
    assign ev = fire ? (20'h0_0001 << kind) : 20'h0_0000;
    // Active low, idles high between reports
    assign sec_serr_n = ~ev[19];
endmodule

/* test/tb_top.sv */
// Self-checking bench for the bridge error reporting block.
// Assumes the register port answers one cycle after the read strobe.

`timescale 1ns/100ps

module tb_top
    import ber_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [4:0] kind = 5'h00;
    logic fire = 1'b0;
    logic wr_tgt = 1'b0;
    logic rd_ini = 1'b0;
    logic as_tgt = 1'b0;
    logic [19:0] ev;
    logic sec_serr_n, sec_perr_o, sec_perr_oe, pri_serr_o, pri_serr_oe;
    logic pri_locked, sec_locked, discard_pw, discard_dw, fail_dr;
    int fail_count = 0;
    int total_checks = 0;
    // Reference model state
    logic [1:0] cmd_m = 2'h0;
    logic [2:0] bctl_m = 3'h0;
    logic [7:0] dis_m = 8'h00;
    logic [7:0] cause_m = 8'h00;
    logic pstat_m = 1'b0;
    logic sstat_m = 1'b0;
    logic [2:0] lock_m = 3'h0;
    int cnt[3] = '{0, 0, 0};

    // Clock at 125 MHz
    initial
    begin
        forever #4 clock = ~clock;
    end

    // ------------------------------------------------------------
    // Design and far-side model
    // ------------------------------------------------------------
    // Short retry counter so the limit is reached in eight retries
    ber_core #(.RETRY_W(3)) u_dut (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sec_wr_target(wr_tgt), .sec_rd_init(rd_ini), .sec_par_err(ev[8]),
        .up_dw_pri_perr(ev[9]), .sec_perr_o(sec_perr_o), .sec_perr_oe(sec_perr_oe),
        .up_pw_pri_perr(ev[0]), .dn_pw_sec_perr(ev[1]), .pw_perr_as_target(as_tgt),
        .sec_serr_n(sec_serr_n), .pw_target_abort(ev[2]), .pw_master_abort(ev[3]),
        .pw_retry(ev[4]), .pw_done(ev[10]), .dw_retry(ev[5]), .dw_done(ev[11]),
        .dr_retry(ev[6]), .dr_done(ev[12]), .dly_master_timeout(ev[7]),
        .pri_serr_o(pri_serr_o), .pri_serr_oe(pri_serr_oe), .pri_lock_set(ev[13]),
        .pri_lock_clr(ev[14]), .sec_lock_set(ev[15]), .sec_lock_clr(ev[16]),
        .cross_lock_set(ev[17]), .cross_lock_clr(ev[18]), .pri_locked(pri_locked),
        .sec_locked(sec_locked), .discard_pw(discard_pw), .discard_dw(discard_dw),
        .fail_dr(fail_dr));

    ber_bus_model u_bus (.kind(kind), .fire(fire), .ev(ev), .sec_serr_n(sec_serr_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask

    // Read data are valid only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    // Random enables, biased so gated paths open often; readback checks widths
    task automatic cfg();
        logic [31:0] d;
        logic [31:0] v;
        d = $urandom | (($urandom_range(3, 0) != 0) ? 32'h0000_0003 : 32'h0000_0000);
        wr(BER_OFF_CMD, d);
        cmd_m = d[1:0];
        d = $urandom | (($urandom_range(3, 0) != 0) ? 32'h0000_0007 : 32'h0000_0000);
        wr(BER_OFF_BCTL, d);
        bctl_m = d[2:0];
        d = $urandom_range(1, 0) ? $urandom : 32'h0000_0000;
        wr(BER_OFF_DIS, d);
        dis_m = d[7:0];
        rd(BER_OFF_CMD, v);
        chk(v, {30'h0, cmd_m}, "cmd readback");
        rd(BER_OFF_BCTL, v);
        chk(v, {29'h0, bctl_m}, "bctl readback");
        rd(BER_OFF_DIS, v);
        chk(v, {24'h0, dis_m}, "disable readback");
    endtask

    // Flags hold until written with ones, then clear
    task automatic chk_regs();
        logic [31:0] v;
        rd(BER_OFF_PSTAT, v);
        chk(v, {31'h0, pstat_m}, "signalled flag");
        rd(BER_OFF_SSTAT, v);
        chk(v, {31'h0, sstat_m}, "received flag");
        rd(BER_OFF_CAUSE, v);
        chk(v, {24'h0, cause_m}, "cause");
        wr(BER_OFF_PSTAT, 32'hFFFF_FFFF);
        wr(BER_OFF_SSTAT, 32'hFFFF_FFFF);
        wr(BER_OFF_CAUSE, 32'hFFFF_FFFF);
        pstat_m = 1'b0;
        sstat_m = 1'b0;
        cause_m = 8'h00;
    endtask

    // One bus event, then compare the pin, discard and lock outputs against the model
    task automatic fire_ev(input int k);
        logic t, w, lim, se, sp;
        int cb;
        t = 1'($urandom_range(1, 0));
        w = (k == 9) ? 1'b1 : 1'($urandom_range(1, 0));
        lim = 1'b0;
        se = 1'b0;
        @(posedge clock);
        kind <= k[4:0];
        fire <= 1'b1;
        as_tgt <= t;
        wr_tgt <= w;
        rd_ini <= 1'($urandom_range(1, 0));
        @(posedge clock);
        fire <= 1'b0;
        #1;
        if (k >= 4 && k <= 6)
        begin
            cnt[k - 4]++;
            lim = (cnt[k - 4] == 8);
            if (lim)
                cnt[k - 4] = 0;
        end
        if (k >= 10 && k <= 12)
            cnt[k - 10] = 0;
        if (k <= 1)
            se = cmd_m[1] & cmd_m[0] & bctl_m[0] & !t & !dis_m[0];
        else if (k <= 6)
            se = cmd_m[1] & !dis_m[k - 1] & ((k < 4) | lim);
        else if (k == 7)
            se = cmd_m[1] & bctl_m[2];
        else if (k == 19)
            se = cmd_m[1] & bctl_m[1] & !dis_m[7];
        sp = bctl_m[0] & (((k == 8) & (w | rd_ini)) | ((k == 9) & cmd_m[0]));
        if (k >= 13 && k <= 18)
            lock_m[(k - 13) / 2] = ((k - 13) % 2 == 0);
        cb = (k <= 1) ? 0 : ((k == 19) ? 7 : k - 1);
        if (se)
        begin
            cause_m[cb] = 1'b1;
            pstat_m = 1'b1;
        end
        if (k == 19)
            sstat_m = 1'b1;
        chk(32'(pri_serr_oe), 32'(se), "serr");
        chk(32'(sec_perr_oe), 32'(sp), "sec perr");
        // Both pins are pulled low only through their enables
        chk({30'h0, pri_serr_o, sec_perr_o}, 32'h0000_0000, "pin level");
        chk({29'h0, fail_dr, discard_dw, discard_pw}, 32'(lim) << (k - 4), "discard");
        chk({30'h0, sec_locked, pri_locked},
            {30'h0, lock_m[1] | lock_m[2], lock_m[0] | lock_m[2]}, "locks");
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] v;
        void'($urandom(32'hb0f7));
        // Second pass opens with a reset in mid-run, while flags and locks may be set; the retry counts are back at zero
        for (int pass = 0; pass < 2; pass++)
        begin
            @(posedge clock);
            arst_n <= 1'b0;
            repeat (10) @(posedge clock);
            #1;
            chk({25'h0, pri_serr_oe, sec_perr_oe, pri_locked, sec_locked, discard_pw,
                discard_dw, fail_dr}, 32'h0000_0000, "outputs in reset");
            @(posedge clock);
            arst_n <= 1'b1;
            cmd_m = 2'h0;
            bctl_m = 3'h0;
            dis_m = 8'h00;
            cause_m = 8'h00;
            pstat_m = 1'b0;
            sstat_m = 1'b0;
            lock_m = 3'h0;
            cnt = '{0, 0, 0};
            // All registers clear after reset; the unmapped slots at 0x1C and 0x20 read zero
            for (int a = 0; a <= 32; a += 4)
            begin
                rd(8'(a), v);
                chk(v, 32'h0000_0000, "reset value");
            end
            for (int i = 0; i < 300; i++)
            begin
                if (i % 15 == 0)
                begin
                    chk_regs();
                    cfg();
                end
                fire_ev($urandom_range(19, 0));
            end
            // Retry limits, with a completion part-way resetting the count
            for (int k = 4; k <= 6; k++)
            begin
                repeat (5) fire_ev(k);
                fire_ev(k + 6);
                repeat (8) fire_ev(k);
            end
        end
        chk_regs();
        wrap_up();
    end

    // Hang guard
    initial
    begin
        repeat (60000) @(posedge clock);
        fail_count++;
        $display("BAD t=%0t run did not finish", $time);
        wrap_up();
    end
endmodule

/* verilog/ber_core.sv */
// Bridge error reporting: secondary parity-error output, primary system-error
// output, status/cause flags, event disables and independent lock tracking.
// Assumes all event inputs are one-cycle pulses synchronous to clock; the bus
// logic outside supplies transaction role, direction and parity results.
//
// Functional notes
// - Secondary parity error driven for own detection only as write target/read initiator with enable set.
// - Secondary parity-response enable lives in bridge control, apart from command.
// - Upstream delayed write: primary target perr drives secondary perr if both enabled.
// - System error for perr seen on upstream or downstream posted write.
// - No system error for posted parity error detected as the write's target.
// - Posted parity system error needs both parity-response enables set.
// - System error output never asserted unless command system-error enable set.
// - Each system error assertion sets signalled-system-error in primary status.
// - Secondary system error input forwarded when forward enable is set.
// - Secondary system error input sets received flag in secondary status.
// - Target abort on forwarded posted write may raise system error.
// - Master abort on forwarded posted write may raise system error.
// - Posted write dropped after 2**24 retries, may raise system error.
// - Delayed write dropped after 2**24 retries, may raise system error.
// - Delayed read failing after 2**24 retries may raise system error.
// - Master timeout gated by its bridge control bit, no disable bit.
// - Cause register records which event raised system error.
// - Per-event disable bits suppress system error for their cause.
// - Primary and secondary locks independent, linked only by crossing lock.
//
// The plain strobed port and the register offsets are this design's own decisions.

`timescale 1ns/100ps

module ber_core
    import ber_pkg::*;
#(
    parameter int RETRY_W = BER_RETRY_EXP
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Secondary bus parity context
    input wire logic sec_wr_target,
    input wire logic sec_rd_init,
    input wire logic sec_par_err,
    input wire logic up_dw_pri_perr,
    output logic sec_perr_o,
    output logic sec_perr_oe,
    // Posted write parity events
    input wire logic up_pw_pri_perr,
    input wire logic dn_pw_sec_perr,
    input wire logic pw_perr_as_target,
    // Other system error events
    input wire logic sec_serr_n,
    input wire logic pw_target_abort,
    input wire logic pw_master_abort,
    input wire logic pw_retry,
    input wire logic pw_done,
    input wire logic dw_retry,
    input wire logic dw_done,
    input wire logic dr_retry,
    input wire logic dr_done,
    input wire logic dly_master_timeout,
    output logic pri_serr_o,
    output logic pri_serr_oe,
    // Lock tracking
    input wire logic pri_lock_set,
    input wire logic pri_lock_clr,
    input wire logic sec_lock_set,
    input wire logic sec_lock_clr,
    input wire logic cross_lock_set,
    input wire logic cross_lock_clr,
    output logic pri_locked,
    output logic sec_locked,
    output logic discard_pw,
    output logic discard_dw,
    output logic fail_dr
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [1:0] cmd_r;
    logic [2:0] bctl_r;
    logic sig_serr_r;
    logic rcv_serr_r;
    logic [BER_NEV-1:0] cause_r;
    logic [BER_NEV-1:0] dis_r;
    logic [31:0] rdata_r;
    logic sec_perr_r;
    logic pri_serr_r;
    logic pri_lock_r;
    logic sec_lock_r;
    logic cross_r;
    logic [RETRY_W-1:0] pw_cnt_r;
    logic [RETRY_W-1:0] dw_cnt_r;
    logic [RETRY_W-1:0] dr_cnt_r;
    logic [2:0] lim_r;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire wr_cmd = reg_wr && (reg_addr == BER_OFF_CMD);
    wire wr_bctl = reg_wr && (reg_addr == BER_OFF_BCTL);
    wire wr_pstat = reg_wr && (reg_addr == BER_OFF_PSTAT);
    wire wr_sstat = reg_wr && (reg_addr == BER_OFF_SSTAT);
    wire wr_cause = reg_wr && (reg_addr == BER_OFF_CAUSE);
    wire wr_dis = reg_wr && (reg_addr == BER_OFF_DIS);

    wire pri_perr_en = cmd_r[BER_CMD_PERR_EN];
    wire serr_en = cmd_r[BER_CMD_SERR_EN];
    wire sec_perr_en = bctl_r[BER_BCTL_PERR_EN];
    wire serr_fwd = bctl_r[BER_BCTL_SERR_FWD];
    wire mto_en = bctl_r[BER_BCTL_MTO_SERR];

    // Secondary parity error: own detection in the proper role, or primary
    // target error relayed on an upstream delayed write
    wire sec_perr_own = (sec_wr_target || sec_rd_init) && sec_perr_en && sec_par_err;
    wire sec_perr_relay = up_dw_pri_perr && pri_perr_en && sec_perr_en;
    wire sec_perr_nxt = sec_perr_own || sec_perr_relay;

    // Retry limits: a counter per queue reaching all ones on a retry
    wire pw_lim = pw_retry && (&pw_cnt_r);
    wire dw_lim = dw_retry && (&dw_cnt_r);
    wire dr_lim = dr_retry && (&dr_cnt_r);

    // Raw events before disables
    logic [BER_NEV-1:0] ev_raw;
    assign ev_raw[BER_EV_PAR] = (up_pw_pri_perr || dn_pw_sec_perr) && !pw_perr_as_target
        && pri_perr_en && sec_perr_en;
    assign ev_raw[BER_EV_TABT] = pw_target_abort;
    assign ev_raw[BER_EV_MABT] = pw_master_abort;
    assign ev_raw[BER_EV_PWRTY] = pw_lim;
    assign ev_raw[BER_EV_DWRTY] = dw_lim;
    assign ev_raw[BER_EV_DRRTY] = dr_lim;
    assign ev_raw[BER_EV_MTO] = dly_master_timeout && mto_en;
    assign ev_raw[BER_EV_SERR] = !sec_serr_n && serr_fwd;

    // Disable mask; timeout has no disable bit
    logic [BER_NEV-1:0] ev_mask;
    assign ev_mask = dis_r & ~(BER_NEV'(1) << BER_EV_MTO);
    logic [BER_NEV-1:0] ev_gated;
    assign ev_gated = ev_raw & ~ev_mask & {BER_NEV{serr_en}};
    wire serr_nxt = |ev_gated;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_r <= BER_CMD_RST;
            bctl_r <= BER_BCTL_RST;
            dis_r <= BER_DIS_RST;
        end
        else
        begin
            if (wr_cmd)
                cmd_r <= reg_wdata[1:0];
            if (wr_bctl)
                bctl_r <= reg_wdata[2:0];
            if (wr_dis)
                dis_r <= reg_wdata[BER_NEV-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Sticky flags, set wins over a write-one clear
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sig_serr_r <= 1'b0;
            rcv_serr_r <= 1'b0;
            cause_r <= BER_CAUSE_RST;
        end
        else
        begin
            sig_serr_r <= serr_nxt || (sig_serr_r
                && !(wr_pstat && reg_wdata[BER_PSTAT_SIG_SERR]));
            rcv_serr_r <= !sec_serr_n || (rcv_serr_r
                && !(wr_sstat && reg_wdata[BER_SSTAT_RCV_SERR]));
            cause_r <= ev_gated | (cause_r
                & ~(wr_cause ? reg_wdata[BER_NEV-1:0] : '0));
        end
    end

    // ----------------------------------------------------------------
    // Retry counters; cleared on delivery and on wrap at the limit
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pw_cnt_r <= '0;
            dw_cnt_r <= '0;
            dr_cnt_r <= '0;
            lim_r <= 3'h0;
        end
        else
        begin
            pw_cnt_r <= pw_done ? '0 : (pw_retry ? pw_cnt_r + 1'b1 : pw_cnt_r);
            dw_cnt_r <= dw_done ? '0 : (dw_retry ? dw_cnt_r + 1'b1 : dw_cnt_r);
            dr_cnt_r <= dr_done ? '0 : (dr_retry ? dr_cnt_r + 1'b1 : dr_cnt_r);
            lim_r <= {dr_lim, dw_lim, pw_lim};
        end
    end
    assign discard_pw = lim_r[0];
    assign discard_dw = lim_r[1];
    assign fail_dr = lim_r[2];

    // ----------------------------------------------------------------
    // Pin drivers: open-drain style, drive low while asserting
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sec_perr_r <= 1'b0;
            pri_serr_r <= 1'b0;
        end
        else
        begin
            sec_perr_r <= sec_perr_nxt;
            pri_serr_r <= serr_nxt;
        end
    end
    assign sec_perr_o = 1'b0;
    assign sec_perr_oe = sec_perr_r;
    assign pri_serr_o = 1'b0;
    assign pri_serr_oe = pri_serr_r;

    // ----------------------------------------------------------------
    // Locks: each side tracks its own; a crossing lock ties both
    // ----------------------------------------------------------------
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pri_lock_r <= 1'b0;
            sec_lock_r <= 1'b0;
            cross_r <= 1'b0;
        end
        else
        begin
            pri_lock_r <= pri_lock_set || (pri_lock_r && !pri_lock_clr);
            sec_lock_r <= sec_lock_set || (sec_lock_r && !sec_lock_clr);
            cross_r <= cross_lock_set || (cross_r && !cross_lock_clr);
        end
    end
    // Concurrent locks on both sides are legal and never interfere
    assign pri_locked = pri_lock_r || cross_r;
    assign sec_locked = sec_lock_r || cross_r;

    // ----------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ----------------------------------------------------------------
    logic [31:0] rd_mux;
    assign rd_mux = (reg_addr == BER_OFF_CMD) ? {30'h0, cmd_r}
        : (reg_addr == BER_OFF_BCTL) ? {29'h0, bctl_r}
        : (reg_addr == BER_OFF_PSTAT) ? {31'h0, sig_serr_r}
        : (reg_addr == BER_OFF_SSTAT) ? {31'h0, rcv_serr_r}
        : (reg_addr == BER_OFF_CAUSE) ? {24'h0, cause_r}
        : (reg_addr == BER_OFF_DIS) ? {24'h0, dis_r}
        : (reg_addr == BER_OFF_LOCK) ? {29'h0, cross_r, sec_lock_r, pri_lock_r}
        : 32'h0000_0000;
    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            rdata_r <= 32'h0000_0000;
        else
            rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
    end
    assign reg_rdata = rdata_r;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_sec_perr_cause;
        @(posedge clock) disable iff (!arst_n)
        sec_perr_oe |-> $past(sec_perr_en) && ($past(sec_wr_target) || $past(sec_rd_init)
            || ($past(up_dw_pri_perr) && $past(pri_perr_en)));
    endproperty
    a_sec_perr_cause: assert property (p_sec_perr_cause)
        else $error("secondary parity error without cause");

    property p_relay;
        @(posedge clock) disable iff (!arst_n)
        (up_dw_pri_perr && pri_perr_en && sec_perr_en) |=> sec_perr_oe;
    endproperty
    a_relay: assert property (p_relay)
        else $error("relayed parity error missing");

    property p_serr_en;
        @(posedge clock) disable iff (!arst_n)
        pri_serr_oe |-> $past(serr_en);
    endproperty
    a_serr_en: assert property (p_serr_en)
        else $error("system error without enable");

    property p_sig_flag;
        @(posedge clock) disable iff (!arst_n)
        pri_serr_oe |-> sig_serr_r;
    endproperty
    a_sig_flag: assert property (p_sig_flag)
        else $error("signalled flag not set");

    property p_fwd;
        @(posedge clock) disable iff (!arst_n)
        (!sec_serr_n && serr_fwd && serr_en && !dis_r[BER_EV_SERR]) |=> pri_serr_oe
            && cause_r[BER_EV_SERR];
    endproperty
    a_fwd: assert property (p_fwd)
        else $error("secondary system error not forwarded");

    property p_rcv;
        @(posedge clock) disable iff (!arst_n)
        !sec_serr_n |=> rcv_serr_r;
    endproperty
    a_rcv: assert property (p_rcv)
        else $error("received flag not set");

    property p_par_target;
        @(posedge clock) disable iff (!arst_n)
        $rose(cause_r[BER_EV_PAR]) |-> !$past(pw_perr_as_target);
    endproperty
    a_par_target: assert property (p_par_target)
        else $error("target parity raised system error");

    property p_par_both;
        @(posedge clock) disable iff (!arst_n)
        $rose(cause_r[BER_EV_PAR]) |-> $past(pri_perr_en) && $past(sec_perr_en);
    endproperty
    a_par_both: assert property (p_par_both)
        else $error("parity system error with enable clear");

    property p_mto;
        @(posedge clock) disable iff (!arst_n)
        (dly_master_timeout && mto_en && serr_en) |=> pri_serr_oe;
    endproperty
    a_mto: assert property (p_mto)
        else $error("timeout not reported despite disable");

    property p_sticky;
        @(posedge clock) disable iff (!arst_n)
        (sig_serr_r && !(wr_pstat && reg_wdata[BER_PSTAT_SIG_SERR])) |=> sig_serr_r;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status flag lost");

endmodule

/* verilog/ber_pkg.sv */
// Package for the bridge error reporting block: register offsets, bit positions,
// reset values and cycle constants.
// Assumes a plain register port with read data one cycle after the read strobe.
package ber_pkg;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] BER_OFF_CMD = 8'h00;   // Command: parity resp, serr enable
    localparam logic [7:0] BER_OFF_BCTL = 8'h04;  // Bridge control
    localparam logic [7:0] BER_OFF_PSTAT = 8'h08; // Primary status
    localparam logic [7:0] BER_OFF_SSTAT = 8'h0C; // Secondary status
    localparam logic [7:0] BER_OFF_CAUSE = 8'h10; // System error cause
    localparam logic [7:0] BER_OFF_DIS = 8'h14;   // System error event disable
    localparam logic [7:0] BER_OFF_LOCK = 8'h18;  // Lock state view

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BER_CMD_PERR_EN = 0;
    localparam int BER_CMD_SERR_EN = 1;
    localparam int BER_BCTL_PERR_EN = 0;
    localparam int BER_BCTL_SERR_FWD = 1;
    localparam int BER_BCTL_MTO_SERR = 2;
    localparam int BER_PSTAT_SIG_SERR = 0;
    localparam int BER_SSTAT_RCV_SERR = 0;

    // Cause / disable bit positions, one per event
    localparam int BER_EV_PAR = 0;    // Posted write parity
    localparam int BER_EV_TABT = 1;   // Posted write target abort
    localparam int BER_EV_MABT = 2;   // Posted write master abort
    localparam int BER_EV_PWRTY = 3;  // Posted write retry limit
    localparam int BER_EV_DWRTY = 4;  // Delayed write retry limit
    localparam int BER_EV_DRRTY = 5;  // Delayed read retry limit
    localparam int BER_EV_MTO = 6;    // Master timeout (no disable bit)
    localparam int BER_EV_SERR = 7;   // Forwarded secondary system error
    localparam int BER_NEV = 8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [1:0] BER_CMD_RST = 2'h0;
    localparam logic [2:0] BER_BCTL_RST = 3'h0;
    localparam logic [7:0] BER_DIS_RST = 8'h00;
    localparam logic [7:0] BER_CAUSE_RST = 8'h00;

    // Retry limit exponent: 2**24 retries
    localparam int BER_RETRY_EXP = 24;

endpackage
